// ===== ofd_decoder.sv
// Operand field decoder: takes operand bytes tagged with their kind and
// registers the decoded fields. Also sequences the two-register add.
// Assumes bytes arrive one per valid strobe from the fetch unit on clk.
`timescale 1ns/1ps
// Functional notes
// RULE_01: Add opcode 04 takes source then destination
// RULE_02: Register byte addresses locations 0 to 255
// RULE_03: Escaped byte selects working register R0-R15
// RULE_04: Bit field selects bit 0 to 7
// RULE_05: Direct address is full 16 bits
// RULE_06: Extended register address is 12 bits
// RULE_07: Register pairs are always even
// RULE_08: Relative target is next address plus signed
// RULE_09: Indexed address is base plus signed index
// RULE_10: Immediate is one full data byte
// RULE_11: Polarity bit selects cleared or set test
// RULE_12: Vector selects one of 256 locations
// RULE_13: Upper nibble E marks escaped register byte
module ofd_decoder (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Operand byte stream
   input  wire logic        in_valid,
   input  wire logic [7:0]  in_byte,
   input  wire logic [3:0]  in_kind,
   input  wire logic        in_opcode,
   // Context
   input  wire logic [3:0]  reg_ptr,
   input  wire logic [15:0] next_pc,
   input  wire logic [15:0] index_base,
   // Decoded fields
   output logic      [11:0] reg_addr,
   output logic             reg_escaped,
   output logic      [2:0]  bit_sel,
   output logic      [7:0]  bit_mask,
   output logic             polarity,
   output logic      [7:0]  imm_data,
   output logic      [15:0] direct_addr,
   output logic      [11:0] ext_addr,
   output logic      [15:0] rel_target,
   output logic      [15:0] idx_addr,
   output logic      [7:0]  vector,
   output logic             field_valid,
   // Two-register add
   output logic      [11:0] add_src,
   output logic      [11:0] add_dst,
   output logic             add_ready
);
   logic [11:0] map_loc;
   logic        map_esc;

   logic [11:0] reg_addr_r, reg_addr_nxt;
   logic        esc_r, esc_nxt;
   logic [2:0]  bit_r, bit_nxt;
   logic        pol_r, pol_nxt;
   logic [7:0]  imm_r, imm_nxt;
   logic [15:0] da_r, da_nxt;
   logic [11:0] ext_r, ext_nxt;
   logic [15:0] rel_r, rel_nxt;
   logic [15:0] idx_r, idx_nxt;
   logic [7:0]  vec_r, vec_nxt;
   logic [7:0]  mask_r, mask_nxt;
   logic        fv_r, fv_nxt;

   ofd_pkg::ofd_state_e st_r, st_nxt;
   logic [11:0] src_r, src_nxt;
   logic [11:0] dst_r, dst_nxt;
   logic        ar_r, ar_nxt;

   // Sign-extends an 8-bit displacement and adds it to a 16-bit base
   function automatic logic [15:0] add_disp(input logic [15:0] base,
                                            input logic [7:0]  disp);
      add_disp = base + {{8{disp[7]}}, disp};
   endfunction

   // One-hot mask for a 3-bit bit index
   function automatic logic [7:0] bit_onehot(input logic [2:0] idx);
      bit_onehot = 8'h01 << idx;
   endfunction

   ofd_regmap u_map (
      .addr_byte (in_byte),
      .reg_ptr   (reg_ptr),
      .reg_loc   (map_loc),
      .escaped   (map_esc)
   );

   always_comb begin
      reg_addr_nxt = reg_addr_r;
      esc_nxt      = esc_r;
      bit_nxt      = bit_r;
      pol_nxt      = pol_r;
      imm_nxt      = imm_r;
      da_nxt       = da_r;
      ext_nxt      = ext_r;
      rel_nxt      = rel_r;
      idx_nxt      = idx_r;
      vec_nxt      = vec_r;
      mask_nxt     = mask_r;
      fv_nxt       = 1'b0;
      if (in_valid && !in_opcode) begin
         fv_nxt = 1'b1;
         case (in_kind)
            ofd_pkg::OFD_K_REG: begin
               reg_addr_nxt = map_loc; // RULE_02
               esc_nxt      = map_esc; // RULE_03
            end
            ofd_pkg::OFD_K_REGPR: begin
               reg_addr_nxt = {map_loc[11:1], 1'b0}; // RULE_07
               esc_nxt      = map_esc;
            end
            ofd_pkg::OFD_K_WREGPR: begin
               reg_addr_nxt = {reg_ptr, reg_ptr, in_byte[3:1], 1'b0}; // RULE_07
               esc_nxt      = 1'b1;
            end
            ofd_pkg::OFD_K_BIT: begin
               bit_nxt  = in_byte[2:0]; // RULE_04
               mask_nxt = bit_onehot(in_byte[2:0]); // RULE_04
            end
            ofd_pkg::OFD_K_POL: begin
               pol_nxt = in_byte[0]; // RULE_11
            end
            ofd_pkg::OFD_K_IMM: begin
               imm_nxt = in_byte; // RULE_10
            end
            ofd_pkg::OFD_K_DAHI: begin
               da_nxt = {in_byte, da_r[7:0]}; // RULE_05
            end
            ofd_pkg::OFD_K_DALO: begin
               da_nxt = {da_r[15:8], in_byte}; // RULE_05
            end
            ofd_pkg::OFD_K_EXTHI: begin
               ext_nxt = {in_byte[3:0], ext_r[7:0]}; // RULE_06
            end
            ofd_pkg::OFD_K_EXTLO: begin
               ext_nxt = {ext_r[11:8], in_byte}; // RULE_06
            end
            ofd_pkg::OFD_K_REL: begin
               rel_nxt = add_disp(next_pc, in_byte); // RULE_08
            end
            ofd_pkg::OFD_K_IDX: begin
               idx_nxt = add_disp(index_base, in_byte); // RULE_09
            end
            ofd_pkg::OFD_K_VEC: begin
               vec_nxt = in_byte; // RULE_12
            end
            default: begin
               fv_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         reg_addr_r <= 12'h000;
         esc_r      <= 1'b0;
         bit_r      <= 3'h0;
         pol_r      <= 1'b0;
         imm_r      <= 8'h00;
         da_r       <= 16'h0000;
         ext_r      <= 12'h000;
         rel_r      <= 16'h0000;
         idx_r      <= 16'h0000;
         vec_r      <= 8'h00;
         mask_r     <= 8'h01;
         fv_r       <= 1'b0;
      end else begin
         reg_addr_r <= reg_addr_nxt;
         esc_r      <= esc_nxt;
         bit_r      <= bit_nxt;
         pol_r      <= pol_nxt;
         imm_r      <= imm_nxt;
         da_r       <= da_nxt;
         ext_r      <= ext_nxt;
         rel_r      <= rel_nxt;
         idx_r      <= idx_nxt;
         vec_r      <= vec_nxt;
         mask_r     <= mask_nxt;
         fv_r       <= fv_nxt;
      end
   end

   // Add sequencer: opcode, then source byte, then destination byte
   always_comb begin
      st_nxt  = st_r;
      src_nxt = src_r;
      dst_nxt = dst_r;
      ar_nxt  = 1'b0;
      case (st_r)
         ofd_pkg::OFD_S_OPC: begin
            if (in_valid && in_opcode && in_byte == ofd_pkg::OPC_ADD_RR) begin
               st_nxt = ofd_pkg::OFD_S_SRC; // RULE_01
            end
         end
         ofd_pkg::OFD_S_SRC: begin
            if (in_valid) begin
               src_nxt = map_loc; // RULE_01
               st_nxt  = ofd_pkg::OFD_S_DST;
            end
         end
         ofd_pkg::OFD_S_DST: begin
            if (in_valid) begin
               dst_nxt = map_loc; // RULE_01
               ar_nxt  = 1'b1;
               st_nxt  = ofd_pkg::OFD_S_OPC;
            end
         end
         default: st_nxt = ofd_pkg::OFD_S_OPC;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_r  <= ofd_pkg::OFD_S_OPC;
         src_r <= 12'h000;
         dst_r <= 12'h000;
         ar_r  <= 1'b0;
      end else begin
         st_r  <= st_nxt;
         src_r <= src_nxt;
         dst_r <= dst_nxt;
         ar_r  <= ar_nxt;
      end
   end

   // Mask is registered beside the index so the output leaves a flop
   assign bit_mask    = mask_r;
   assign reg_addr    = reg_addr_r;
   assign reg_escaped = esc_r;
   assign bit_sel     = bit_r;
   assign polarity    = pol_r;
   assign imm_data    = imm_r;
   assign direct_addr = da_r;
   assign ext_addr    = ext_r;
   assign rel_target  = rel_r;
   assign idx_addr    = idx_r;
   assign vector      = vec_r;
   assign field_valid = fv_r;
   assign add_src     = src_r;
   assign add_dst     = dst_r;
   assign add_ready   = ar_r;
endmodule

// ===== ofd_pkg.sv
// Package for the CPU operand field decoder: opcodes, field layouts, ranges.
// Assumes nothing beyond a SystemVerilog compiler.
package ofd_pkg;
   localparam logic [7:0]  OPC_ADD_RR    = 8'h04;
   localparam logic [3:0]  ESC_NIBBLE    = 4'he;
   localparam int          BIT_W         = 3;
   localparam int          REG_W         = 8;
   localparam int          EXT_W         = 12;
   localparam int          PC_W          = 16;
   localparam int          WREG_W        = 4;
   localparam logic [3:0]  RP_RESET      = 4'h0;

   // Operand kinds presented with each operand byte
   typedef enum logic [3:0] {
      OFD_K_REG    = 4'h0,
      OFD_K_REGPR  = 4'h1,
      OFD_K_WREGPR = 4'h2,
      OFD_K_BIT    = 4'h3,
      OFD_K_POL    = 4'h4,
      OFD_K_IMM    = 4'h5,
      OFD_K_DAHI   = 4'h6,
      OFD_K_DALO   = 4'h7,
      OFD_K_EXTHI  = 4'h8,
      OFD_K_EXTLO  = 4'h9,
      OFD_K_REL    = 4'ha,
      OFD_K_IDX    = 4'hb,
      OFD_K_VEC    = 4'hc
   } ofd_kind_e;

   // Decoder sequence for the two-register add
   typedef enum logic [1:0] {
      OFD_S_OPC = 2'b00,
      OFD_S_SRC = 2'b01,
      OFD_S_DST = 2'b10
   } ofd_state_e;
endpackage

// ===== ofd_regmap.sv
// Maps an 8-bit register address byte to a 12-bit register location.
// Assumes the caller supplies the current register pointer.
`timescale 1ns/1ps
module ofd_regmap (
   // Address byte and pointer
   input  wire logic [7:0]  addr_byte,
   input  wire logic [3:0]  reg_ptr,
   // Result
   output logic      [11:0] reg_loc,
   output logic             escaped
);
   always_comb begin
      escaped = (addr_byte[7:4] == ofd_pkg::ESC_NIBBLE); // RULE_13
      if (escaped) begin
         // Working register: pointer selects the 16-byte group
         reg_loc = {reg_ptr, reg_ptr, addr_byte[3:0]}; // RULE_03
      end else begin
         reg_loc = {4'h0, addr_byte}; // RULE_02
      end
   end
endmodule

// ===== ofd_decoder_chk.sv
// Assertions on the operand field decoder's ports.
// Assumes binding to ofd_decoder, one clock, srst synchronous.
`timescale 1ns/1ps
module ofd_decoder_chk (
   // Clock and reset
   input wire logic        clk,
   input wire logic        srst,
   // Byte stream and context
   input wire logic        in_valid,
   input wire logic [7:0]  in_byte,
   input wire logic [3:0]  in_kind,
   input wire logic        in_opcode,
   input wire logic [3:0]  reg_ptr,
   input wire logic [15:0] next_pc,
   input wire logic [15:0] index_base,
   // Decoded fields
   input wire logic [11:0] reg_addr,
   input wire logic        reg_escaped,
   input wire logic [2:0]  bit_sel,
   input wire logic [7:0]  bit_mask,
   input wire logic        polarity,
   input wire logic [7:0]  imm_data,
   input wire logic [15:0] direct_addr,
   input wire logic [11:0] ext_addr,
   input wire logic [15:0] rel_target,
   input wire logic [15:0] idx_addr,
   input wire logic [7:0]  vector,
   input wire logic        field_valid,
   input wire logic        add_ready
);
   logic [3:0]  k;
   logic        esc;
   logic [11:0] reg_e;
   logic [15:0] rel_e;
   logic [15:0] idx_e;
   // Kind of an operand byte taken this cycle, 4'hf when none
   assign k = (in_valid && !in_opcode) ? in_kind : 4'hf;
   assign esc = in_byte[7:4] == ofd_pkg::ESC_NIBBLE;
   assign reg_e = esc ? {reg_ptr, reg_ptr, in_byte[3:0]} : {4'h0, in_byte};
   assign rel_e = next_pc + {{8{in_byte[7]}}, in_byte};
   assign idx_e = index_base + {{8{in_byte[7]}}, in_byte};
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   imm_data_a: assert property (k == ofd_pkg::OFD_K_IMM
      |=> imm_data == $past(in_byte)) else $error("immediate wrong");
   vec_data_a: assert property (k == ofd_pkg::OFD_K_VEC
      |=> vector == $past(in_byte)) else $error("vector wrong");
   bit_field_a: assert property (k == ofd_pkg::OFD_K_BIT
      |=> bit_sel == 3'($past(in_byte))) else $error("bit index wrong");
   pol_bit_a: assert property (k == ofd_pkg::OFD_K_POL
      |=> polarity == 1'($past(in_byte))) else $error("polarity wrong");
   rel_target_a: assert property (k == ofd_pkg::OFD_K_REL
      |=> rel_target == $past(rel_e)) else $error("relative wrong");
   idx_addr_a: assert property (k == ofd_pkg::OFD_K_IDX
      |=> idx_addr == $past(idx_e)) else $error("indexed wrong");
   pair_even_a: assert property (k == ofd_pkg::OFD_K_REGPR
      |=> !reg_addr[0]) else $error("pair address odd");
   reg_map_a: assert property (k == ofd_pkg::OFD_K_REG
      |=> reg_addr == $past(reg_e)) else $error("register map wrong");
   esc_flag_a: assert property (k == ofd_pkg::OFD_K_REG
      |=> reg_escaped == $past(esc)) else $error("escape flag wrong");
   dir_hi_a: assert property (k == ofd_pkg::OFD_K_DAHI
      |=> direct_addr[15:8] == $past(in_byte)) else $error("direct wrong");
   ext_lo_a: assert property (k == ofd_pkg::OFD_K_EXTLO
      |=> ext_addr[7:0] == $past(in_byte)) else $error("extended wrong");
   add_seq_a: assert property ((in_valid && in_opcode &&
      in_byte == ofd_pkg::OPC_ADD_RR) ##1 (k != 4'hf) [*2] |=> add_ready)
      else $error("add not ready");
   bit_mask_a: assert property (k == ofd_pkg::OFD_K_BIT
      |=> bit_mask == 8'h01 << $past(in_byte[2:0]))
      else $error("bit mask wrong");
   field_set_a: assert property (k <= ofd_pkg::OFD_K_VEC
      |=> field_valid) else $error("field valid missing");
   field_none_a: assert property (k > ofd_pkg::OFD_K_VEC
      |=> !field_valid) else $error("field valid unexpected");
endmodule
bind ofd_decoder ofd_decoder_chk u_chk (
   .clk         (clk),
   .srst        (srst),
   .in_valid    (in_valid),
   .in_byte     (in_byte),
   .in_kind     (in_kind),
   .in_opcode   (in_opcode),
   .reg_ptr     (reg_ptr),
   .next_pc     (next_pc),
   .index_base  (index_base),
   .reg_addr    (reg_addr),
   .reg_escaped (reg_escaped),
   .bit_sel     (bit_sel),
   .bit_mask    (bit_mask),
   .polarity    (polarity),
   .imm_data    (imm_data),
   .direct_addr (direct_addr),
   .ext_addr    (ext_addr),
   .rel_target  (rel_target),
   .idx_addr    (idx_addr),
   .vector      (vector),
   .field_valid (field_valid),
   .add_ready   (add_ready)
);

// ===== tb_top.sv
// Self-checking bench for the operand field decoder.
// Assumes the checker is bound separately; inputs change on negedge.
`timescale 1ns/1ps
module tb_top;
   logic        clk = 0, srst = 1, in_valid = 0, in_opcode = 0;
   logic [3:0]  in_kind = 0, reg_ptr = 0;
   logic [7:0]  in_byte = 0, bit_mask, imm_data, vector, b;
   logic [11:0] reg_addr, ext_addr, add_src, add_dst;
   logic [15:0] next_pc = 0, index_base = 0, direct_addr, rel_target, idx_addr;
   logic [2:0]  bit_sel;
   logic        reg_escaped, polarity, field_valid, add_ready;
   logic [31:0] seed = 32'h00000c12, r;
   logic [7:0]  cb [6] = '{8'h00, 8'hff, 8'h7f, 8'h80, 8'he0, 8'hef};
   int          err_count = 0, checked = 0, i;
   always #4 clk = ~clk;
   ofd_decoder dut (
      .clk         (clk),
      .srst        (srst),
      .in_valid    (in_valid),
      .in_byte     (in_byte),
      .in_kind     (in_kind),
      .in_opcode   (in_opcode),
      .reg_ptr     (reg_ptr),
      .next_pc     (next_pc),
      .index_base  (index_base),
      .reg_addr    (reg_addr),
      .reg_escaped (reg_escaped),
      .bit_sel     (bit_sel),
      .bit_mask    (bit_mask),
      .polarity    (polarity),
      .imm_data    (imm_data),
      .direct_addr (direct_addr),
      .ext_addr    (ext_addr),
      .rel_target  (rel_target),
      .idx_addr    (idx_addr),
      .vector      (vector),
      .field_valid (field_valid),
      .add_src     (add_src),
      .add_dst     (add_dst),
      .add_ready   (add_ready)
   );
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [16:0] s, input logic [16:0] e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("mismatch at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task automatic put(input logic o, input logic [3:0] k, input logic [7:0] v);
      in_valid = 1;
      in_opcode = o;
      in_kind = k;
      in_byte = v;
      @(negedge clk);
   endtask
   // Expected location of a register byte, escaped or plain
   function automatic logic [11:0] map_exp(input logic [7:0] v);
      if (v[7:4] == ofd_pkg::ESC_NIBBLE)
         return {reg_ptr, reg_ptr, v[3:0]};
      return {4'h0, v};
   endfunction
   task automatic ck(input logic [3:0] k, input logic [7:0] v);
      logic [15:0] sx;
      logic [11:0] m;
      logic [11:0] w;
      sx = {{8{v[7]}}, v};
      m = map_exp(v);
      w = {reg_ptr, reg_ptr, v[3:1], 1'b0};
      case (k)
         4'h0: begin
            chk({field_valid, reg_addr}, {1'b1, m});
            chk(reg_escaped, v[7:4] == ofd_pkg::ESC_NIBBLE);
         end
         4'h1: begin
            chk({field_valid, reg_addr}, {1'b1, m[11:1], 1'b0});
            chk(reg_escaped, v[7:4] == ofd_pkg::ESC_NIBBLE);
         end
         4'h2: begin
            chk({field_valid, reg_addr}, {1'b1, w});
            chk(reg_escaped, 1'b1);
         end
         4'h3: begin
            chk({field_valid, bit_mask}, {1'b1, 8'h01 << v[2:0]});
            chk(bit_sel, v[2:0]);
         end
         4'h4: chk({field_valid, polarity}, {1'b1, v[0]});
         4'h5: chk({field_valid, imm_data}, {1'b1, v});
         4'h6: chk({field_valid, direct_addr[15:8]}, {1'b1, v});
         4'h7: chk({field_valid, direct_addr[7:0]}, {1'b1, v});
         4'h8: chk({field_valid, ext_addr[11:8]}, {1'b1, v[3:0]});
         4'h9: chk({field_valid, ext_addr[7:0]}, {1'b1, v});
         4'ha: chk({field_valid, rel_target}, {1'b1, next_pc + sx});
         4'hb: begin
            chk({field_valid, idx_addr}, {1'b1, index_base + sx});
         end
         default: chk({field_valid, vector}, {1'b1, v});
      endcase
   endtask
   task automatic finish_test();
      $display("errors %0d, checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      // Tests take about 300 cycles; allow a wide margin
      repeat (2000) @(posedge clk);
      err_count++;
      finish_test();
   end
   initial begin
      repeat (3) @(negedge clk);
      srst = 0;
      // Corner bytes for every kind, then random kinds and bytes
      for (i = 0; i < 278; i++) begin
         r = rnd();
         reg_ptr = r[19:16];
         next_pc = r[31:16];
         index_base = 16'(rnd());
         b = i < 78 ? cb[i % 6] : r[15:8];
         put(0, 4'(i < 78 ? i / 6 : r % 13), b);
         ck(in_kind, b);
      end
      // Undefined kind: no field changes and no valid pulse
      b = imm_data;
      put(0, 4'hd, 8'h5a);
      chk({field_valid, imm_data}, {1'b0, b});
      // Add opcode, then a non-add opcode with the same operands
      for (i = 0; i < 2; i++) begin
         put(1, 0, i ? 8'h05 : ofd_pkg::OPC_ADD_RR);
         put(0, ofd_pkg::OFD_K_REG, 8'he8);
         put(0, ofd_pkg::OFD_K_REG, 8'h43);
         chk(add_ready, i == 0);
      end
      chk(add_src, {reg_ptr, reg_ptr, 4'h8});
      chk(add_dst, 12'h043);
      in_valid = 0;
      @(negedge clk);
      chk(add_ready, 0);
      finish_test();
   end
endmodule
